/* File: static_mem_ctrl_pkg.sv */
// Shared constants, field layout, modes and carriers of the static memory controller.
// Assumes one core clock and a synchronous active-high reset in every user but ext_mem_model, which has none.
`default_nettype none
package static_mem_ctrl_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int CS_COUNT = 4;
    localparam logic [7:0] REG_STRIDE = 8'h10;
    localparam logic [7:0] OFF_SETUP = 8'h00;
    localparam logic [7:0] OFF_PULSE = 8'h04;
    localparam logic [7:0] OFF_CYCLE = 8'h08;
    localparam logic [7:0] OFF_MODE = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h40;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    // Writable bits of each register; reserved bits read as zero
    localparam logic [31:0] SETUP_MASK = 32'h3F3F_3F3F;
    localparam logic [31:0] PULSE_MASK = 32'h7F7F_7F7F;
    localparam logic [31:0] CYCLE_MASK = 32'h01FF_01FF;
    localparam logic [31:0] MODE_MASK = 32'h311F_3133;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int F_WE = 0;
    localparam int F_CS_WR = 8;
    localparam int F_RD = 16;
    localparam int F_CS_RD = 24;
    localparam int M_READ_MODE = 0;
    localparam int M_WRITE_MODE = 1;
    localparam int M_WAIT = 4;
    localparam int M_BAT = 8;
    localparam int M_DBW = 12;
    localparam int M_TDF = 16;
    localparam int M_FLOAT_OPTIMISE_EN = 20;
    localparam int M_PAGE_BURST_EN = 24;
    localparam int M_PS = 28;
    // Weights of the high bits of the length fields
    localparam int SETUP_HI_WEIGHT = 128;
    localparam int PULSE_HI_WEIGHT = 256;
    localparam int CYCLE_HI_WEIGHT = 256;
    localparam int PAGE_BASE_SHIFT = 2;
    // ---------------------------------------------------------------
    // Modes and carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WAIT_OFF = 2'h0, WAIT_RSVD = 2'h1, WAIT_FROZEN = 2'h2, WAIT_READY = 2'h3
    } wait_mode_t;
    typedef enum logic [1:0] {
        WIDTH_8 = 2'h0, WIDTH_16 = 2'h1, WIDTH_32 = 2'h2, WIDTH_RSVD = 2'h3
    } width_t;
    typedef struct packed {
        logic we;
        logic [1:0] cs;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic [3:0] sel;
    } mem_req_t;
    typedef struct packed {
        logic [31:0] mode;
        logic [31:0] cycle;
        logic [31:0] pulse;
        logic [31:0] setup;
    } cs_cfg_t;
    typedef struct packed {
        logic [3:0] chip_sel_n;
        logic read_strobe_n;
        logic write_strobe_n;
        logic [3:0] lane_write_n;
        logic [3:0] lane_select_n;
    } strobes_t;
    // ---------------------------------------------------------------
    // Length decoders
    // ---------------------------------------------------------------
    function automatic logic [9:0] setup_len(input logic [5:0] f);
        setup_len = 10'(f[5] * SETUP_HI_WEIGHT) + 10'(f[4:0]);
    endfunction
    function automatic logic [9:0] pulse_len(input logic [6:0] f);
        pulse_len = 10'(f[6] * PULSE_HI_WEIGHT) + 10'(f[5:0]);
    endfunction
    function automatic logic [9:0] cycle_len(input logic [8:0] f);
        cycle_len = 10'(f[8:7] * CYCLE_HI_WEIGHT) + 10'(f[6:0]);
    endfunction
endpackage
`default_nettype wire

/* File: cfg_regfile.sv */
// Configuration store: four words for each chip select.
// Assumes byte-lane writes from the bus slave; both read ports are registered.
`default_nettype none
module cfg_regfile (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bus port
    input wire logic wr_en,
    input wire logic [3:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] wr_mask,
    input wire logic [3:0] rd_idx,
    output logic [31:0] rd_data,
    // Chip select view for the access engine
    input wire logic [1:0] view_cs,
    output static_mem_ctrl_pkg::cs_cfg_t view
);
    import static_mem_ctrl_pkg::*;

    typedef struct packed {
        logic [15:0][31:0] word;
        logic [31:0] rd;
        cs_cfg_t view;
    } regfile_t;

    regfile_t s_reg;
    regfile_t s_next;

    // Masked write and both registered reads
    always_comb begin
        s_next = s_reg;
        if (wr_en) begin
            s_next.word[wr_idx] = (s_reg.word[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
        s_next.rd = s_reg.word[rd_idx];
        s_next.view = {s_reg.word[{view_cs, 2'h3}], s_reg.word[{view_cs, 2'h2}],
                       s_reg.word[{view_cs, 2'h1}], s_reg.word[{view_cs, 2'h0}]};
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '{word: {16{CFG_RESET}}, rd: 32'h0000_0000, view: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign rd_data = s_reg.rd;
    assign view = s_reg.view;
endmodule
`default_nettype wire

/* File: access_timer.sv */
// Cycle counter of one external access, with a freeze input.
// Assumes the caller pulses start in the cycle before the access's first cycle.
`default_nettype none
module access_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic start,
    input wire logic hold,
    input wire logic [9:0] len,
    // Position
    output logic [9:0] count,
    output logic last
);
    typedef struct packed {
        logic [9:0] cnt;
    } timer_t;

    timer_t s_reg;
    timer_t s_next;

    // A length of zero behaves as one cycle so the access always ends
    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.cnt = 10'h000;
        end else if (!hold && !last) begin
            s_next.cnt = s_reg.cnt + 10'h001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count = s_reg.cnt;
    assign last = (len == 10'h000) || (s_reg.cnt >= len - 10'h001);
endmodule
`default_nettype wire

/* File: static_mem_ctrl.sv */
// Static memory controller: per chip select cycle, pulse, setup and mode handling,
// a classic Wishbone register slave and a single outstanding external access.
// Assumes pins are synchronous to core_clk and the requester waits on req_ready.
//
// Operation
// - Read cycle lasts 256 times cycle field bits 8:7 plus bits 6:0.
// - Write cycle lasts 256 times cycle field bits 8:7 plus bits 6:0.
// - Total cycle spans setup, pulse and hold of strobe and chip select.
// - Page size field selects 4, 8, 16 or 32 byte pages.
// - Page mode bit set gives page burst reads, else single reads.
// - Float optimisation overlaps float wait with next setup, else waits fully.
// - One extra turnaround cycle always follows the float period.
// - Other chip selects blocked for float count plus one cycles, count 0-15.
// - Width field selects 8, 16 or 32 bit bus; 11 reserved.
// - Byte write scheme: per-lane write strobes, reads with read strobe only.
// - Byte select scheme: single write strobe plus lane selects on reads too.
// - Wait input is only looked at in the controlling pulse phase.
// - Wait mode: 00 off, 01 reserved, 10 frozen, 11 ready.
// - Frozen mode stops the access while wait is asserted, then resumes.
// - Ready mode extends the pulse end until wait input returns high.
// - Write mode bit picks write strobe or chip select as write control.
// - Read mode bit picks read strobe or chip select as read control.
// - Bus is marked busy from the rise of the read controlling signal.
// - Setup length is 128 times bit 5 plus bits 4:0.
// - Pulse length is 256 times bit 6 plus bits 5:0, at least one; a zero field gives zero here.
// - Page reads use chip select pulse first, read strobe pulse after.
//
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
module static_mem_ctrl (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Wishbone register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Access requests
    input wire logic req_valid,
    input wire static_mem_ctrl_pkg::mem_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // External memory pins
    output static_mem_ctrl_pkg::strobes_t strobes,
    output logic [23:0] ext_addr,
    output logic [31:0] data_out,
    output logic data_oe,
    input wire logic [31:0] data_in,
    input wire logic ext_wait_n
);
    import static_mem_ctrl_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_FLOAT = 4'b0100,
        ST_ACCESS = 4'b1000
    } state_t;

    typedef struct packed {
        state_t st;
        logic ack;
        logic rd_status;
        logic [31:0] status;
        mem_req_t cur;
        logic page_hit;
        logic page_open;
        logic [1:0] page_cs;
        logic [23:0] page_tag;
        logic [4:0] float_cnt;
        logic [1:0] float_cs;
        logic float_opt;
        logic rsp;
        logic [31:0] rdata;
        logic [23:0] addr;
        logic [31:0] wdata;
        logic oe;
    } ctrl_t;

    ctrl_t s_reg;
    ctrl_t s_next;

    cs_cfg_t cfg;
    logic [31:0] mem_rd;
    logic [31:0] wr_mask;
    logic mem_wr;
    logic [9:0] t;
    logic t_last;
    logic t_start;
    logic hold;

    // Page tag drops the byte offset inside a page of 4 << size bytes
    function automatic logic [23:0] page_tag(input logic [23:0] a, input logic [1:0] ps);
        page_tag = a >> (PAGE_BASE_SHIFT + int'(ps));
    endfunction

    // True while t lies inside a pulse window
    function automatic logic in_win(input logic [9:0] t, input logic [9:0] su,
                                    input logic [9:0] pl);
        in_win = (t >= su) && (t < su + pl);
    endfunction

    // ---------------------------------------------------------------
    // Register slave
    // ---------------------------------------------------------------
    // Writes land on the edge that ends ack, the edge the master samples
    assign mem_wr = wb_cyc_i && wb_stb_i && wb_we_i && s_reg.ack && (wb_adr_i < OFF_STATUS);
    always_comb begin
        logic [31:0] lanes;
        lanes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        unique case (wb_adr_i[3:0])
            OFF_SETUP[3:0]: wr_mask = lanes & SETUP_MASK;
            OFF_PULSE[3:0]: wr_mask = lanes & PULSE_MASK;
            OFF_CYCLE[3:0]: wr_mask = lanes & CYCLE_MASK;
            OFF_MODE[3:0]: wr_mask = lanes & MODE_MASK;
            default: wr_mask = 32'h0000_0000;
        endcase
    end

    cfg_regfile u_cfg (
        .core_clk(core_clk),
        .reset(reset),
        .wr_en(mem_wr),
        .wr_idx(wb_adr_i[5:2]),
        .wr_data(wb_dat_i),
        .wr_mask(wr_mask),
        .rd_idx(wb_adr_i[5:2]),
        .rd_data(mem_rd),
        .view_cs(s_reg.st == ST_IDLE ? req.cs : s_reg.cur.cs),
        .view(cfg)
    );

    // ---------------------------------------------------------------
    // Decoded configuration of the current chip select
    // ---------------------------------------------------------------
    logic rd_by_strobe;
    logic wr_by_strobe;
    wait_mode_t wmode;
    width_t width;
    logic [3:0] tdf;
    logic [9:0] cs_su;
    logic [9:0] cs_pl;
    logic [9:0] st_su;
    logic [9:0] st_pl;
    logic [9:0] ctl_su;
    logic [9:0] ctl_pl;
    logic [9:0] total;
    logic cs_on;
    logic st_on;
    logic ctl_on;
    logic ctl_end;
    logic [3:0] lane_en;
    logic wide_bw;

    always_comb begin
        rd_by_strobe = cfg.mode[M_READ_MODE];
        wr_by_strobe = cfg.mode[M_WRITE_MODE];
        wmode = wait_mode_t'(cfg.mode[M_WAIT +: 2]);
        width = width_t'(cfg.mode[M_DBW +: 2]);
        tdf = cfg.mode[M_TDF +: 4];
        // Setup and pulse lengths per signal and direction
        if (s_reg.cur.we) begin
            cs_su = setup_len(cfg.setup[F_CS_WR +: 6]);
            st_su = setup_len(cfg.setup[F_WE +: 6]);
            cs_pl = pulse_len(cfg.pulse[F_CS_WR +: 7]);
            st_pl = pulse_len(cfg.pulse[F_WE +: 7]);
            total = cycle_len(cfg.cycle[F_WE +: 9]);
        end else begin
            cs_su = setup_len(cfg.setup[F_CS_RD +: 6]);
            st_su = setup_len(cfg.setup[F_RD +: 6]);
            cs_pl = pulse_len(cfg.pulse[F_CS_RD +: 7]);
            st_pl = pulse_len(cfg.pulse[F_RD +: 7]);
            total = cycle_len(cfg.cycle[F_RD +: 9]);
        end
        // Later page accesses run one read strobe pulse with everything held low
        if (s_reg.page_hit) begin
            total = st_pl;
            cs_su = 10'h000;
            st_su = 10'h000;
            cs_pl = st_pl;
        end
        // Hold is whatever of the total is left after setup and pulse
        cs_on = in_win(t, cs_su, cs_pl);
        st_on = in_win(t, st_su, st_pl);
        if (s_reg.cur.we ? wr_by_strobe : rd_by_strobe) begin
            ctl_su = st_su;
            ctl_pl = st_pl;
            ctl_on = st_on;
        end else begin
            ctl_su = cs_su;
            ctl_pl = cs_pl;
            ctl_on = cs_on;
        end
        ctl_end = (t == ctl_su + ctl_pl - 10'h001);
        // Active byte lanes limited by the bus width
        unique case (width)
            WIDTH_8: lane_en = s_reg.cur.sel & 4'h1;
            WIDTH_16: lane_en = s_reg.cur.sel & 4'h3;
            WIDTH_32: lane_en = s_reg.cur.sel;
            default: lane_en = 4'h0;
        endcase
        wide_bw = (width == WIDTH_16) || (width == WIDTH_32);
    end

    // ---------------------------------------------------------------
    // Wait input
    // ---------------------------------------------------------------
    // Wait only freezes the counter inside the controlling pulse, so its
    // setup and hold stay as programmed; ready mode needs a hold cycle after it
    always_comb begin
        hold = 1'b0;
        if (s_reg.st == ST_ACCESS && ctl_on) begin
            unique case (wmode)
                WAIT_FROZEN: hold = !ext_wait_n;
                WAIT_READY: hold = ctl_end && !ext_wait_n;
                default: hold = 1'b0;
            endcase
        end
    end

    assign t_start = (s_reg.st != ST_ACCESS) && (s_next.st == ST_ACCESS);

    access_timer u_timer (
        .core_clk(core_clk),
        .reset(reset),
        .start(t_start),
        .hold(hold),
        .len(total),
        .count(t),
        .last(t_last)
    );

    // ---------------------------------------------------------------
    // Access sequencer
    // ---------------------------------------------------------------
    logic float_clear;
    logic [9:0] next_ctl_su;

    always_comb begin
        // Setup of the controlling signal of the access about to start
        next_ctl_su = ctl_su;
        // Another chip select waits out the previous read's float period
        float_clear = (s_reg.float_cnt == 5'h00) || (s_reg.float_cs == s_reg.cur.cs);
        if (s_reg.float_opt && (10'(s_reg.float_cnt) <= next_ctl_su)) begin
            float_clear = 1'b1;
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.rsp = 1'b0;
        s_next.ack = wb_cyc_i && wb_stb_i && !s_reg.ack;
        s_next.rd_status = (wb_adr_i == OFF_STATUS);
        s_next.status = {26'h0, s_reg.float_cnt != 5'h00, s_reg.page_open, s_reg.st};
        if (wb_adr_i > OFF_STATUS) begin
            s_next.status = 32'h0000_0000;
        end
        if (s_reg.float_cnt != 5'h00) begin
            s_next.float_cnt = s_reg.float_cnt - 5'h01;
        end
        unique case (s_reg.st)
            ST_IDLE: begin
                if (req_valid) begin
                    s_next.cur = req;
                    s_next.st = ST_LOAD;
                end
            end
            ST_LOAD: begin
                // Page hit only for a read in the open page of a page-mode select
                s_next.page_hit = cfg.mode[M_PAGE_BURST_EN] && !s_reg.cur.we && s_reg.page_open
                    && (s_reg.page_cs == s_reg.cur.cs)
                    && (page_tag(s_reg.cur.addr, cfg.mode[M_PS +: 2]) == s_reg.page_tag);
                s_next.addr = s_reg.cur.addr;
                s_next.wdata = s_reg.cur.wdata;
                s_next.st = float_clear ? ST_ACCESS : ST_FLOAT;
            end
            ST_FLOAT: begin
                if (float_clear) begin
                    s_next.st = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (!s_reg.cur.we && ctl_end && !hold) begin
                    s_next.rdata = data_in;
                    // Float plus one turnaround, counted from the control rise
                    s_next.float_cnt = 5'(tdf) + 5'h01;
                    s_next.float_cs = s_reg.cur.cs;
                    s_next.float_opt = cfg.mode[M_FLOAT_OPTIMISE_EN];
                end
                if (t_last && !hold) begin
                    s_next.rsp = 1'b1;
                    s_next.st = ST_IDLE;
                    s_next.page_hit = 1'b0;
                    s_next.page_open = cfg.mode[M_PAGE_BURST_EN] && !s_reg.cur.we;
                    s_next.page_cs = s_reg.cur.cs;
                    s_next.page_tag = page_tag(s_reg.cur.addr, cfg.mode[M_PS +: 2]);
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
        // Data drives through the whole write access
        s_next.oe = s_reg.cur.we && (s_next.st == ST_ACCESS);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_reg <= '{st: ST_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = s_reg.rd_status || (wb_adr_i >= OFF_STATUS) ? s_reg.status : mem_rd;
    assign req_ready = (s_reg.st == ST_IDLE);
    assign rsp_valid = s_reg.rsp;
    assign rsp_rdata = s_reg.rdata;
    assign ext_addr = s_reg.addr;
    assign data_out = s_reg.wdata;
    assign data_oe = s_reg.oe;

    // Strobes decode from registered counter and configuration only
    always_comb begin
        logic act;
        logic is_wr;
        logic byte_wr;
        act = (s_reg.st == ST_ACCESS);
        is_wr = s_reg.cur.we;
        byte_wr = cfg.mode[M_BAT] && wide_bw;
        strobes = '{chip_sel_n: 4'hF, read_strobe_n: 1'b1, write_strobe_n: 1'b1,
                    lane_write_n: 4'hF, lane_select_n: 4'hF};
        if (act && cs_on) begin
            strobes.chip_sel_n[s_reg.cur.cs] = 1'b0;
        end
        if (act && st_on && !is_wr) begin
            strobes.read_strobe_n = 1'b0;
        end
        if (act && st_on && is_wr) begin
            if (byte_wr) begin
                strobes.lane_write_n = ~lane_en;
            end else begin
                strobes.write_strobe_n = 1'b0;
            end
        end
        if (act && cs_on && !byte_wr) begin
            strobes.lane_select_n = ~lane_en;
        end
    end
endmodule
`default_nettype wire

/* File: static_mem_ctrl_properties.sv */
// Pin and handshake checker for the static memory controller.
// Assumes it is bound to static_mem_ctrl and sees only its ports.
`default_nettype none
module static_mem_ctrl_check (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Watched outputs
    input wire logic rsp_valid,
    input wire static_mem_ctrl_pkg::strobes_t strobes,
    input wire logic data_oe
);
    import static_mem_ctrl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ---------
    // Properties
    // ---------
    property p_one_cs;
        $onehot0(~strobes.chip_sel_n);
    endproperty
    a_one_cs: assert property (p_one_cs)
        else $error("two chip selects low");
    // Bus idle a cycle after release
    property p_cs_gap;
        $rose(&strobes.chip_sel_n) |=> &strobes.chip_sel_n;
    endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("chip select reused at once");
    property p_lane_wr;
        !(&strobes.lane_write_n) |-> strobes.write_strobe_n;
    endproperty
    a_lane_wr: assert property (p_lane_wr)
        else $error("lane write with write strobe");
    property p_lane_sel;
        !(&strobes.lane_select_n) |-> &strobes.lane_write_n;
    endproperty
    a_lane_sel: assert property (p_lane_sel)
        else $error("lane select with lane write");
    property p_rd_oe;
        !strobes.read_strobe_n |-> !data_oe;
    endproperty
    a_rd_oe: assert property (p_rd_oe)
        else $error("bus driven during read");
    property p_wr_oe;
        !strobes.write_strobe_n |-> data_oe;
    endproperty
    a_wr_oe: assert property (p_wr_oe)
        else $error("write strobe without data");
    // Turnaround after a read
    property p_turn;
        $rose(strobes.read_strobe_n) |-> !data_oe ##1 !data_oe;
    endproperty
    a_turn: assert property (p_turn)
        else $error("no turnaround cycle");
    property p_rsp;
        rsp_valid |=> !rsp_valid;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("response longer than a cycle");
    c_read: cover property ($fell(strobes.read_strobe_n));
    c_write: cover property ($fell(strobes.write_strobe_n));
    c_lane: cover property (!(&strobes.lane_write_n));
endmodule
bind static_mem_ctrl static_mem_ctrl_check u_static_mem_ctrl_check (.core_clk(core_clk),
    .reset(reset), .rsp_valid(rsp_valid), .strobes(strobes), .data_oe(data_oe));
`default_nettype wire

/* File: ext_mem_model.sv */
// Asynchronous static memory on chip select 0, sixteen words.
// Assumes pins are sampled on core_clk; stall asks for wait cycles.
`default_nettype none
module ext_mem_model (
    // Clock
    input wire logic core_clk,
    // Pins
    input wire static_mem_ctrl_pkg::strobes_t strobes,
    input wire logic [23:0] ext_addr,
    input wire logic [31:0] data_out,
    output logic [31:0] data_in,
    output logic ext_wait_n,
    // Wait cycles per read pulse
    input wire logic [3:0] stall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [16];
    logic [31:0] last = 32'h0;
    logic [3:0] cnt = 4'h0;
    wire logic rd = !strobes.chip_sel_n[0] && !strobes.read_strobe_n;
    // Released bus shows the inverse, so stale data never matches
    assign data_in = rd ? mem[ext_addr[5:2]] : ~last;
    // Lane writes; wait low early in each read pulse
    always @(posedge core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!strobes.chip_sel_n[0] && (!strobes.lane_write_n[i]
                || (!strobes.write_strobe_n && !strobes.lane_select_n[i])))
                mem[ext_addr[5:2]][8*i+:8] <= data_out[8*i+:8];
        end
        if (rd)
            last <= mem[ext_addr[5:2]];
        ext_wait_n <= !(rd && cnt < stall);
        cnt <= rd ? cnt + 4'(cnt < stall) : 4'h0;
    end
endmodule
`default_nettype wire

/* File: test_static_mem_ctrl.sv */
// Bench for the static memory controller: register and access tests.
// Assumes ext_mem_model on the pins and chip select 0 only.
`default_nettype none
module test_static_mem_ctrl import static_mem_ctrl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, req_valid = 0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, stall = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rsp_rdata, data_out, data_in, rdat;
    logic wb_ack_o, req_ready, rsp_valid, data_oe, ext_wait_n;
    mem_req_t req = '0;
    strobes_t strobes;
    logic [23:0] ext_addr;
    wait_mode_t wm[3] = '{WAIT_OFF, WAIT_FROZEN, WAIT_READY};
    int err_count = 0, n_compared = 0, lat, rd_lo, wr_lo, pre;
    static_mem_ctrl u_static_mem_ctrl (.core_clk(core_clk), .reset(reset),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .strobes(strobes), .ext_addr(ext_addr), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .ext_wait_n(ext_wait_n));
    ext_mem_model u_ext_mem_model (.core_clk(core_clk), .strobes(strobes),
        .ext_addr(ext_addr), .data_out(data_out), .data_in(data_in),
        .ext_wait_n(ext_wait_n), .stall(stall));
    initial forever #10 core_clk = ~core_clk;
    // ---------
    // Tasks
    // ---------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Classic single cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
        do @(posedge core_clk); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // One access; counts cycles and strobe lows
    task automatic acc(input logic w, input logic [31:0] d, input logic [3:0] s);
        @(posedge core_clk);
        req_valid <= 1'b1;
        req <= '{w, 2'h0, 24'h10, d, s};
        do @(posedge core_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        {lat, rd_lo, wr_lo, pre} = '0;
        do begin
            @(posedge core_clk);
            lat++;
            rd_lo += int'(!strobes.read_strobe_n);
            wr_lo += int'(!(&{strobes.write_strobe_n, strobes.lane_write_n}));
            pre += int'(rd_lo == 0);
        end while (rsp_valid !== 1'b1);
    endtask
    function automatic logic [31:0] md(input logic b, input logic [1:0] d, input logic [1:0] t);
        md = 32'h3 | 32'(b) << M_BAT | 32'(d) << M_DBW | 32'(t) << M_WAIT;
    endfunction
    task automatic stop_test;
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ---------
    // Tests
    // ---------
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        wb(0, OFF_MODE, 0, 4'hF);
        chk(rdat, CFG_RESET);
        wb(1, OFF_CYCLE, '1, 4'hF);
        wb(0, OFF_CYCLE, 0, 4'hF);
        chk(rdat, CYCLE_MASK);
        wb(1, OFF_MODE, '1, 4'h1);
        wb(0, OFF_MODE, 0, 4'hF);
        chk(rdat, MODE_MASK & 32'hFF);
        wb(1, 8'h80, '1, 4'hF);
        wb(0, 8'h80, 0, 4'hF);
        chk(rdat, 32'h0);
        $display("Test registers done");
        // High-bit weights of the read length fields, then byte lane schemes
        wb(1, OFF_SETUP, 32'h2121_0102, 4'hF);
        wb(1, OFF_PULSE, 32'h4343_0503, 4'hF);
        wb(1, OFF_CYCLE, 32'h0185_000C, 4'hF);
        wb(1, OFF_MODE, md(1, WIDTH_32, WAIT_OFF), 4'hF);
        acc(1, 32'h1122_3344, 4'hF);
        chk(lat, 14);
        chk(wr_lo, 3);
        acc(0, 0, 4'hF);
        chk(lat, 775);
        chk(rd_lo, 259);
        chk(pre, 130);
        chk(rsp_rdata, 32'h1122_3344);
        wb(1, OFF_MODE, md(0, WIDTH_32, WAIT_OFF), 4'hF);
        acc(1, 32'hAABB_CCDD, 4'h2);
        wb(1, OFF_MODE, md(1, WIDTH_8, WAIT_OFF), 4'hF);
        acc(1, 32'h5566_7788, 4'hF);
        $display("Test timing and lanes done");
        wb(1, OFF_PULSE, 32'h0303_0503, 4'hF);
        stall <= 4'h8;
        foreach (wm[i]) begin
            wb(1, OFF_MODE, md(1, WIDTH_32, wm[i]), 4'hF);
            acc(0, 0, 4'hF);
            chk(rsp_rdata, 32'h1122_CC88);
            chk(lat - rd_lo, 772);
            chk(rd_lo > 3, wm[i][1]);
        end
        wb(1, OFF_MODE, md(1, WIDTH_32, 0) | 1 << M_PAGE_BURST_EN, 4'hF);
        repeat (2) acc(0, 0, 4'hF);
        chk(lat, 5);
        $display("Test modes done");
        stop_test();
    end
    // Watchdog: about five times the expected run
    initial begin
        #400_000;
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
endmodule
`default_nettype wire
